/* hw/ccd_top.sv */
// Card clock generator with serial command port and voltage status flags.
// Assumes serial pins and the input clock are synchronous to sys_clk.
//
// How it works
// - two-bit select: low, /1, /2, /4
// - command bits taken only while select low
// - divider resynchronised on last stage
// - ratio one passes input duty through
// - edge slope selectable any time
// - every write updates card reset bit
// - supply faults flag status, pull interrupt low
// - battery faults recorded in status byte
// - current limit raises no flag
// - route divided clock or command bit
// - byte applied on select rising edge
// - first three bits must match address
`timescale 1ns/100ps
`default_nettype none

module ccd_top #(
   parameter logic [2:0] CHIP_ADDR = 3'h3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Serial command port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   // Input clock and mode
   input wire logic clk_in,
   input wire logic sync_mode,
   // Voltage monitors and current limit
   input wire ccd_pkg::ccd_sense_t sense,
   input wire logic current_limit,
   // Card side
   output logic card_clock_out,
   output logic card_reset_out,
   output logic slow_edge,
   output logic fast_edge,
   // Status and interrupt
   output logic [7:0] status_byte,
   output logic int_n
);

   // All controller state
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic clk;
      logic [7:0] shift;
      logic [3:0] nbits;
      logic addr_ok;
      logic [7:0] tx;
      ccd_pkg::ccd_cfg_t cfg;
      logic [3:0] flags;
   } ccd_st_t;

   ccd_st_t s_q;
   ccd_st_t s_d;
   // Divider output before the mode mux
   logic div_clk;
   // High in the one cycle that closes a valid frame
   logic apply_now;

   // Bit count that completes a command frame
   localparam logic [3:0] BYTE_FULL = 4'(ccd_pkg::CCD_BYTE_BITS);
   // Count at which the last address bit arrives
   localparam logic [3:0] ADDR_LAST = 4'(ccd_pkg::CCD_ADDR_BITS - 1);

   ////////////////////////////////////////////////////////////////
   // frame closes full and addressed
   // Shared by the settings load and the flag clear so both agree
   function automatic logic frame_done(input logic was_n, input logic now_n, input logic [3:0] cnt, input logic hit);
      return !was_n && now_n && (cnt == BYTE_FULL) && hit;
   endfunction : frame_done

   // Select rising edge seen against the previous pin sample
   assign apply_now = frame_done(s_q.cs_n, spi_cs_n, s_q.nbits, s_q.addr_ok);

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.sclk = spi_sclk;
      s_d.cs_n = spi_cs_n;
      s_d.clk = clk_in;
      // Frame start clears the shifter and loads status for readout
      if (s_q.cs_n && !spi_cs_n) begin
         s_d.shift = '0;
         s_d.nbits = '0;
         s_d.addr_ok = 1'b0;
         s_d.tx = status_byte;
      end
      if (!spi_cs_n && !s_q.cs_n && spi_sclk && !s_q.sclk) begin
         s_d.shift = {s_q.shift[6:0], spi_mosi};
         s_d.tx = {s_q.tx[6:0], 1'b0};
         // Count saturates, so longer frames keep the last eight bits
         if (s_q.nbits != BYTE_FULL) begin
            s_d.nbits = s_q.nbits + 4'h1;
         end
         if (s_q.nbits == ADDR_LAST) begin
            s_d.addr_ok = ({s_q.shift[1:0], spi_mosi} == CHIP_ADDR);
         end
      end
      if (apply_now) begin
         s_d.cfg.ratio = {s_q.shift[ccd_pkg::CCD_RATIO_MSB_BIT], s_q.shift[ccd_pkg::CCD_RATIO_LSB_BIT]};
         s_d.cfg.fast_edge = s_q.shift[ccd_pkg::CCD_SLOPE_BIT];
         s_d.cfg.card_reset = s_q.shift[ccd_pkg::CCD_RST_BIT];
         s_d.cfg.clock_route = s_q.shift[ccd_pkg::CCD_ROUTE_BIT];
      end
      // sticky supply flags, battery flags; current limit ignored
      s_d.flags = s_q.flags | {sense.battery_under, sense.battery_over, sense.supply_under, sense.supply_over};
      // Valid frame close clears latched flags unless still asserted (set wins)
      if (apply_now) begin
         s_d.flags = {sense.battery_under, sense.battery_over, sense.supply_under, sense.supply_over};
      end
      if (rst) begin
         s_d = '0;
         s_d.sclk = 1'b0;
         s_d.cs_n = 1'b1;
         s_d.cfg.ratio = ccd_pkg::CCD_RATIO_RST;
         s_d.cfg.card_reset = ccd_pkg::CCD_CARD_RST_RST;
         s_d.cfg.fast_edge = ccd_pkg::CCD_SLOPE_RST;
         s_d.cfg.clock_route = ccd_pkg::CCD_ROUTE_RST;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////
   // ratio divider
   ccd_divider u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_in_level(s_q.clk),
      .clk_in_rise(clk_in && !s_q.clk),
      .ratio(s_q.cfg.ratio),
      .card_clock_out(div_clk)
   );

   // route divided clock or command bit
   assign card_clock_out = sync_mode ? s_q.cfg.clock_route : div_clk;
   assign card_reset_out = s_q.cfg.card_reset;
   assign fast_edge = s_q.cfg.fast_edge;
   assign slow_edge = ~s_q.cfg.fast_edge;
   // Status layout: low nibble flags, upper bits zero
   assign status_byte = {4'h0, s_q.flags};
   assign int_n = ~(s_q.flags[ccd_pkg::CCD_ST_SUP_OVER] | s_q.flags[ccd_pkg::CCD_ST_SUP_UNDER]);
   assign spi_miso = s_q.tx[7] & ~s_q.cs_n;

   // Current limit deliberately has no effect on status
   logic unused_ok;
   assign unused_ok = current_limit;

endmodule : ccd_top
`default_nettype wire

/* include/ccd_pkg.sv */
// Shared constants and carrier types for the card clock divider block.
// Assumes a single 250 MHz system clock; serial port pins arrive synchronous to it.
package ccd_pkg;

   // Card clock ratio select codes
   typedef enum logic [1:0] {
      CCD_RATIO_LOW  = 2'h0,
      CCD_RATIO_DIV1 = 2'h1,
      CCD_RATIO_DIV2 = 2'h2,
      CCD_RATIO_DIV4 = 2'h3
   } ccd_ratio_t;

   // Command byte field positions (bits 7..5 carry the chip address)
   localparam int CCD_ADDR_MSB = 7;
   localparam int CCD_ADDR_LSB = 5;
   localparam int CCD_RST_BIT = 4;
   localparam int CCD_ROUTE_BIT = 3;
   localparam int CCD_SLOPE_BIT = 2;
   localparam int CCD_RATIO_MSB_BIT = 1;
   localparam int CCD_RATIO_LSB_BIT = 0;
   localparam int CCD_BYTE_BITS = 8;
   localparam int CCD_ADDR_BITS = 3;

   // Values after reset
   localparam logic [1:0] CCD_RATIO_RST = 2'h0;
   localparam logic CCD_CARD_RST_RST = 1'b0;
   localparam logic CCD_SLOPE_RST = 1'b0;
   localparam logic CCD_ROUTE_RST = 1'b0;

   // Status byte layout
   localparam int CCD_ST_SUP_OVER = 0;
   localparam int CCD_ST_SUP_UNDER = 1;
   localparam int CCD_ST_BAT_OVER = 2;
   localparam int CCD_ST_BAT_UNDER = 3;

   // Applied card clock settings
   typedef struct packed {
      logic [1:0] ratio;
      logic fast_edge;
      logic card_reset;
      logic clock_route;
   } ccd_cfg_t;

   // Voltage monitor inputs
   typedef struct packed {
      logic supply_over;
      logic supply_under;
      logic battery_over;
      logic battery_under;
   } ccd_sense_t;

endpackage : ccd_pkg

/* hw/ccd_divider.sv */
// Card clock divider: ratio select and 50% duty output stage.
// Assumes a one-cycle input clock enable tick from the top level.
`timescale 1ns/100ps
`default_nettype none

module ccd_divider (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Input clock level and rising-edge tick
   input wire logic clk_in_level,
   input wire logic clk_in_rise,
   // Ratio select
   input wire logic [1:0] ratio,
   // Divided card clock
   output logic card_clock_out
);

   // All divider state
   typedef struct packed {
      logic [1:0] cnt;
      logic [1:0] ratio;
      logic out;
   } ccd_div_st_t;

   ccd_div_st_t s_q;
   ccd_div_st_t s_d;

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      if (clk_in_rise) begin
         s_d.cnt = s_q.cnt + 2'h1;
         // Ratio taken only when the last stage wraps, keeps halves equal
         if (s_q.cnt == 2'h3) begin
            s_d.ratio = ratio;
         end
         unique case (ccd_pkg::ccd_ratio_t'(s_q.ratio))
            // Stopped low
            ccd_pkg::CCD_RATIO_LOW: s_d.out = 1'b0;
            ccd_pkg::CCD_RATIO_DIV1: s_d.out = 1'b0;
            // Toggle each input rising edge gives half rate
            ccd_pkg::CCD_RATIO_DIV2: s_d.out = ~s_d.cnt[0];
            // Last stage bit gives quarter rate
            ccd_pkg::CCD_RATIO_DIV4: s_d.out = ~s_d.cnt[1];
         endcase
      end
      if (rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      s_q <= s_d;
   end

   assign card_clock_out = (s_q.ratio == ccd_pkg::CCD_RATIO_DIV1) ? clk_in_level : s_q.out;

endmodule : ccd_divider
`default_nettype wire

/* testbench/ccd_top_properties.sv */
// Port checker for the card clock top.
// Assumes one clock, sync high reset.
`timescale 1ns/100ps
`default_nettype none
module ccd_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Watched ports
   input wire logic spi_cs_n,
   input wire logic spi_miso,
   input wire ccd_pkg::ccd_sense_t sense,
   input wire logic card_clock_out,
   input wire logic slow_edge,
   input wire logic fast_edge,
   input wire logic [7:0] status_byte,
   input wire logic int_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // No fault for three cycles; covers sense sync lag
   sequence s_calm;
      (sense == 4'h0 && status_byte == 8'h00) [*3];
   endsequence
   // Select seen high twice
   sequence s_idle;
      spi_cs_n && $past(spi_cs_n);
   endsequence
   property p_stop; $fell(rst) |-> !card_clock_out; endproperty
   a_stop: assert property (p_stop) else $error("clock not low");
   property p_slope; slow_edge == !fast_edge; endproperty
   a_slope: assert property (p_slope) else $error("slope pair");
   property p_int; status_byte[1:0] != 2'h0 |-> ##[0:1] !int_n; endproperty
   a_int: assert property (p_int) else $error("int high");
   property p_sup; sense.supply_over |-> ##[1:3] status_byte[0]; endproperty
   a_sup: assert property (p_sup) else $error("supply flag");
   property p_bat; sense.battery_under |-> ##[1:3] status_byte[3]; endproperty
   a_bat: assert property (p_bat) else $error("battery flag");
   property p_quiet; s_calm |=> status_byte == 8'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("stray flag");
   property p_miso; s_idle |-> !spi_miso; endproperty
   a_miso: assert property (p_miso) else $error("miso active");
   property p_apply; $changed(fast_edge) |-> s_idle; endproperty
   a_apply: assert property (p_apply) else $error("early apply");
endmodule : ccd_props
bind ccd_top ccd_props u_props (.sys_clk, .rst, .spi_cs_n, .spi_miso, .sense,
   .card_clock_out, .slow_edge, .fast_edge, .status_byte, .int_n);
`default_nettype wire

/* testbench/ccd_host.sv */
// Host model for the serial command port.
// Assumes pins sampled on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module ccd_host (
   // Clock
   input wire logic sys_clk,
   // Serial pins
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   // Status bit back from the block
   input wire logic spi_miso
);
   // Status bits captured during the last frame
   logic [7:0] rx = 8'h00;
   // Idle: deselected, clock low
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // Step just past n edges
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // Address first, MSB first, select rise closes
   task automatic send(input logic [7:0] b, input int n);
      tick(1);
      rx = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         tick(2);
         spi_mosi = b[i];
         spi_sclk = 1'b0;
         tick(2);
         // Status bit stands until this rising edge shifts it
         rx = {rx[6:0], spi_miso};
         spi_sclk = 1'b1;
      end
      tick(2);
      spi_sclk = 1'b0;
      // Released line shows inverse, not a held bit
      spi_mosi = ~spi_mosi;
      tick(2);
      spi_cs_n = 1'b1;
   endtask : send
endmodule : ccd_host
`default_nettype wire

/* testbench/tb_card_clock_divider.sv */
// Bench for the card clock top.
// Assumes host model and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_card_clock_divider;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_in = 1'b0;
   logic sync_mode = 1'b0;
   logic current_limit = 1'b0;
   ccd_pkg::ccd_sense_t sense = 4'h0;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, card_clock_out, card_reset_out, slow_edge, fast_edge, int_n;
   logic [7:0] status_byte, rises, hi, lo;
   logic [7:0] len = 8'h00;
   logic last = 1'b0;
   logic [15:0] lfsr = 16'h2ED2;
   logic [15:0] prev;
   logic [15:0] exp_q[$];
   int errors = 0;
   int checks = 0;
   event probe;
   always #2 sys_clk = ~sys_clk;
   // Input clock 15.6 MHz keeps every ratio legal
   initial begin
      #3;
      forever #32 clk_in = ~clk_in;
   end
   ccd_top uut (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .clk_in, .sync_mode, .sense,
      .current_limit, .card_clock_out, .card_reset_out, .slow_edge, .fast_edge, .status_byte, .int_n);
   ccd_host host (.sys_clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
   //////////////////////////////////////////
   // Card clock rises and last pulse lengths
   always @(posedge card_clock_out) rises <= rises + 8'h01;
   always @(posedge sys_clk) begin
      len <= len + 8'h01;
      if (card_clock_out !== last) begin
         if (last) hi <= len;
         else lo <= len;
         len <= 8'h01;
      end
      last <= card_clock_out;
   end
   // Oldest note against outputs now
   always @(probe) begin
      check({rises, hi == lo, card_reset_out, fast_edge, int_n, status_byte[3:0]}, exp_q.pop_front());
      check({8'h00, host.rx}, exp_q.pop_front());
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR outputs expected %h seen %h", exp, seen);
      end
   endtask : check
   function automatic logic [15:0] step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : step
   // Write, settle, count a 64 pulse window, post note
   task automatic run(input logic [7:0] b, input int n, input logic [15:0] e, input logic [7:0] st);
      host.send(b, n);
      // Ratio may land four input pulses late
      repeat (80) @(posedge sys_clk);
      #1 rises = 8'h00;
      hi = 8'h00;
      lo = 8'h00;
      repeat (1024) @(posedge sys_clk);
      #1 exp_q.push_back(e);
      exp_q.push_back({8'h00, st});
      prev = e;
      -> probe;
      $display("test %h done", b);
   endtask : run
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      // All ratios, random reset and slope bits
      for (int r = 0; r < 4; r++) begin
         lfsr = step(lfsr);
         run({3'h3, lfsr[1], 1'b0, lfsr[0], 2'(r)}, 8, {((r == 0) ? 8'h00 : 8'h80 >> r), 1'b1, lfsr[1], lfsr[0], 1'b1, 4'h0}, 8'h00);
      end
      run(8'hBF, 8, prev, 8'h00);
      run(8'h70, 5, prev, 8'h00);
      sense.supply_over = 1'b1;
      run(8'h61, 8, 16'h4081, 8'h01);
      sense = 4'h0;
      run(8'h61, 8, 16'h4090, 8'h01);
      sense.battery_under = 1'b1;
      current_limit = 1'b1;
      run(8'h61, 8, 16'h4098, 8'h08);
      sense = 4'h0;
      run(8'h61, 8, 16'h4090, 8'h08);
      sense.supply_under = 1'b1;
      sense.battery_over = 1'b1;
      run(8'h61, 8, 16'h4086, 8'h06);
      sense = 4'h0;
      run(8'h61, 8, 16'h4090, 8'h06);
      sync_mode = 1'b1;
      run(8'h69, 8, 16'h0090, 8'h00);
      test_done();
   end
   // Hang guard
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule : tb_card_clock_divider
`default_nettype wire
